// *** include/lpmc_params.svh ***
/*
 Constants of the low-power mode controller.
 Assumes one 125 MHz clock; definitions only.
*/
`ifndef LPMC_PARAMS_SVH
`define LPMC_PARAMS_SVH

// Widths
`define NUM_IO 16
`define NUM_WAKE 8
`define BO_LVL_W 3
`define DIV_W 4
`define CNT_W 12

// Clock rate and wake-up times in ns
`define CLK_MHZ 125
`define STOP0_WAKE_NS 400
`define STOP1_WAKE_NS 2000
`define STOP2_WAKE_NS 5000
`define STANDBY_WAKE_NS 16000

// Brown-out threshold after power-on
`define BO_LVL_LOWEST 3'h0

// Clock ceiling in low-power run and its source rate, in kHz
`define LPRUN_MAX_KHZ 2000
`define FAST_RC_KHZ 16000

// Wake sources still live in the deeper modes
`define STOP2_WAKE_MASK 8'h0F
`define STANDBY_WAKE_MASK 8'h03

// Reset value of the core clock divider (log2)
`define CPU_DIV_RST 4'h0

`endif

// *** include/lpmc_pkg.sv ***
/*
 Types of the mode controller: states, selections, structs.
 Assumes lpmc_params.svh on the include path.
*/
`include "lpmc_params.svh"

package lpmc_pkg;

   typedef enum logic [3:0] {
      ST_RUN = 4'h0, ST_SLEEP = 4'h1, ST_LPRUN = 4'h3, ST_LPSLEEP = 4'h2,
      ST_STOP0 = 4'h6, ST_STOP1 = 4'h7, ST_STOP2 = 4'h5,
      ST_STANDBY = 4'h4, ST_STOP_EXIT = 4'hC, ST_STBY_EXIT = 4'hD
   } pm_state_type;

   typedef enum logic [1:0] {
      DEEP_STOP0 = 2'h0, DEEP_STOP1 = 2'h1, DEEP_STOP2 = 2'h2,
      DEEP_STANDBY = 2'h3
   } deep_sel_type;

   typedef enum logic {EXIT_MS_RC = 1'b0, EXIT_FAST_RC = 1'b1} exit_clk_type;

   typedef struct packed {
      deep_sel_type deep_sel;
      logic lp_run;
      exit_clk_type exit_clk;
      logic rtc_in_stop;
      logic rtc_in_standby;
      logic secondary_ram_keep;
      logic [`NUM_IO-1:0] io_pu;
      logic [`NUM_IO-1:0] io_pd;
      logic [`DIV_W-1:0] cpu_div;
   } lp_cfg_type;

   typedef struct packed {
      logic cpu_clk_en;
      logic core_clk_en;
      logic pll_en;
      logic multispeed_rc_osc_en;
      logic internal_fast_rc_osc_en;
      logic external_fast_crystal_en;
      logic slow_osc_en;
      logic rtc_en;
      logic periph_fast_rc_ok;
   } clk_gate_type;

   typedef struct packed {
      logic main_reg_on;
      logic lp_reg_on;
      logic core_powered;
      logic low_leakage;
      logic primary_ram_keep;
      logic secondary_ram_keep;
      logic regs_keep;
      logic backup_keep;
   } power_ctrl_type;

endpackage

// *** core/wake_sync.sv ***
/*
 Two-flop synchroniser for wake pins and fast-RC request.
 Assumes inputs asynchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module wake_sync
   import lpmc_pkg::*;
(
   input wire logic sys_clk, // System clock
   input wire logic rstn, // Async reset, active low
   input wire logic [`NUM_WAKE:0] async_in, // Raw pin levels
   output logic [`NUM_WAKE:0] sync_out // Synchronised levels
);

   logic [`NUM_WAKE:0] meta_ff;

   // First flop feeds the second only
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         meta_ff <= '0;
         sync_out <= '0;
      end else begin
         meta_ff <= async_in;
         sync_out <= meta_ff;
      end
   end

endmodule

`default_nettype wire

// *** core/supply_supervisor.sv ***
/*
 Brown-out hold and programmable supply detector.
 Assumes async comparators; options from sys_clk logic.
*/
`timescale 1ns/1ps
`default_nettype none

module supply_supervisor
   import lpmc_pkg::*;
(
   input wire logic sys_clk, // System clock
   input wire logic rstn, // Async reset, active low
   input wire logic bo_below, // Supply below brown-out level, async
   input wire logic det_above, // Supply above detector level, async
   input wire logic [`BO_LVL_W-1:0] opt_level, // Option threshold
   input wire logic opt_valid, // Option settings loaded, pulse
   input wire logic det_en, // Detector switched on by software
   input wire logic rise_en, // Interrupt on rising crossing
   input wire logic fall_en, // Interrupt on falling crossing
   output logic chip_reset_n, // Chip held in reset while low
   output logic [`BO_LVL_W-1:0] bo_level, // Selected threshold
   output logic det_irq, // Crossing interrupt, pulse
   output logic det_level // Synchronised detector level
);

   logic [1:0] meta_ff;
   logic [1:0] sync_ff;
   logic prev_ff;

   // Two-flop synchronisers for both comparators
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         meta_ff <= 2'h0;
         sync_ff <= 2'h0;
      end else begin
         meta_ff <= {det_above, bo_below};
         sync_ff <= meta_ff;
      end
   end

   // Reset stays asserted while supply is below threshold
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) chip_reset_n <= 1'b0;
      else chip_reset_n <= ~sync_ff[0];
   end

   // Lowest threshold after power-on until options load
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) bo_level <= `BO_LVL_LOWEST;
      else if (opt_valid) bo_level <= opt_level;
   end

   // Edge detect, primed while off so enabling raises nothing
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         prev_ff <= 1'b0;
         det_irq <= 1'b0;
         det_level <= 1'b0;
      end else begin
         prev_ff <= sync_ff[1];
         det_level <= sync_ff[1] & det_en;
         det_irq <= det_en & ((rise_en & sync_ff[1] & ~prev_ff) |
                    (fall_en & ~sync_ff[1] & prev_ff));
      end
   end

endmodule

`default_nettype wire

// *** core/low_power_mode_controller.sv ***
/*
 Power-mode sequencer with supply supervision:
 Run, Sleep, low-power modes, Stop 0-2, Standby,
 with clock, regulator, retention and I/O controls.
 Assumes requests and settings on sys_clk;
 wake pins and comparators asynchronous.
*/
// Contract
// - Chip stays in reset while supply is below brown-out level.
// - Brown-out threshold starts lowest; options select higher levels.
// - Brown-out monitor stays on in every mode.
// - Software enables the detector; crossings raise an interrupt.
// - Reset always lands in Run; low-power needs software choice.
// - Sleep stops only the core clock; any event wakes it.
// - Low-power run uses low-power regulator, core clock capped.
// - Low-power run lets peripherals use the fast RC oscillator.
// - Low-power sleep only from low-power run, only core clock stops.
// - Wake from low-power sleep returns to low-power run.
// - Stop gates core clocks and fast oscillators, keeps memory.
// - Real-time clock in Stop follows the software setting.
// - Wake-capable peripherals may request fast RC during Stop.
// - Stop 0 keeps main regulator on; Stop 1 keeps most sources.
// - Stop 2 uses low leakage, fewer wake sources, slower wake.
// - Stop exit clock is multispeed RC or fast RC per software.
// - Standby turns regulator, core power and fast oscillators off.
// - Real-time clock in Standby follows the software setting.
// - Standby holds each I/O pulled up, pulled down or floating.
// - Standby loses primary RAM, keeps backup, secondary optional.
`timescale 1ns/1ps
`default_nettype none

module low_power_mode_controller
   import lpmc_pkg::*;
(
   input wire logic sys_clk, // System clock, 125 MHz
   input wire logic rstn, // Async reset, active low
   input wire logic brownout_below, // Supply under threshold, async
   input wire logic supply_above, // Detector comparator, async
   input wire logic [`BO_LVL_W-1:0] option_bo_level, // Option level
   input wire logic option_valid, // Option settings loaded, pulse
   input wire logic det_en, // Detector enable
   input wire logic det_rise_en, // Interrupt on rising crossing
   input wire logic det_fall_en, // Interrupt on falling crossing
   input wire lp_cfg_type cfg, // Software mode configuration
   input wire logic sleep_req, // Wait-for-interrupt or event, pulse
   input wire logic sleep_deep, // Deep sleep selected with request
   input wire logic [`NUM_WAKE-1:0] wake_evt, // Wake pins, async
   input wire logic periph_fast_rc_req, // Peripheral RC request, async
   output logic chip_reset_n, // Chip reset, active low
   output logic [`BO_LVL_W-1:0] bo_level, // Brown-out threshold
   output logic bo_monitor_en, // Brown-out monitor enable
   output logic supply_detector_en, // Detector enable to analog
   output logic supply_detector_irq, // Detector interrupt, pulse
   output logic supply_level, // Supply above detector level
   output pm_state_type mode, // Current power mode
   output clk_gate_type clk_gate, // Clock and oscillator controls
   output power_ctrl_type pwr_ctrl, // Regulator and retention
   output exit_clk_type sysclk_src, // System clock source
   output logic [`DIV_W-1:0] cpu_div, // Core clock divider, log2
   output logic [`NUM_IO-1:0] io_pull_up, // I/O pull-up hold
   output logic [`NUM_IO-1:0] io_pull_down, // I/O pull-down hold
   output logic standby_exit_reset // Reset on Standby wake, pulse
);

   ////////////////////////////////////////////////////////////////////
   // Helpers

   // Wake time in ns to whole cycles, never below one
   function automatic logic [`CNT_W-1:0] ns_to_cyc(input int ns);
      int c;
      c = (ns * `CLK_MHZ + 999) / 1000;
      if (c < 1) c = 1;
      return `CNT_W'(c);
   endfunction

   // Smallest divider, not below the request, that keeps the core clock at or under the cap
   function automatic logic [`DIV_W-1:0] cap_div(
      input logic [`DIV_W-1:0] req);
      logic [`DIV_W-1:0] d;
      d = req;
      for (int i = 0; i < (1 << `DIV_W) - 1; i++) begin
         if ((`FAST_RC_KHZ >> d) > `LPRUN_MAX_KHZ) d = d + 1'b1;
      end
      return d;
   endfunction

   localparam logic [`CNT_W-1:0] STOP0_CYC = ns_to_cyc(`STOP0_WAKE_NS);
   localparam logic [`CNT_W-1:0] STOP1_CYC = ns_to_cyc(`STOP1_WAKE_NS);
   localparam logic [`CNT_W-1:0] STOP2_CYC = ns_to_cyc(`STOP2_WAKE_NS);
   localparam logic [`CNT_W-1:0] STBY_CYC = ns_to_cyc(`STANDBY_WAKE_NS);
   localparam logic [`NUM_WAKE-1:0] STOP2_MASK = `STOP2_WAKE_MASK;
   localparam logic [`NUM_WAKE-1:0] STBY_MASK = `STANDBY_WAKE_MASK;

   ////////////////////////////////////////////////////////////////////
   // Supervision and synchronisers

   logic [`NUM_WAKE:0] pin_sync;
   logic [`NUM_WAKE-1:0] wake_s;
   logic rc_req_s;

   supply_supervisor u_supervisor (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .bo_below(brownout_below),
      .det_above(supply_above),
      .opt_level(option_bo_level),
      .opt_valid(option_valid),
      .det_en(det_en),
      .rise_en(det_rise_en),
      .fall_en(det_fall_en),
      .chip_reset_n(chip_reset_n),
      .bo_level(bo_level),
      .det_irq(supply_detector_irq),
      .det_level(supply_level)
   );

   wake_sync u_wake_sync (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .async_in({periph_fast_rc_req, wake_evt}),
      .sync_out(pin_sync)
   );

   assign wake_s = pin_sync[`NUM_WAKE-1:0];
   assign rc_req_s = pin_sync[`NUM_WAKE];

   // No shutdown mode here, so the monitor never turns off
   assign bo_monitor_en = 1'b1;

   // Detector power follows software only
   assign supply_detector_en = det_en;

   ////////////////////////////////////////////////////////////////////
   // Mode sequencer

   pm_state_type state_ff;
   pm_state_type nxt_state;
   logic [`CNT_W-1:0] cnt_ff;
   logic [`CNT_W-1:0] nxt_cnt;
   logic any_wake;

   assign any_wake = |wake_s;
   assign mode = state_ff;

   // Next mode from requests, wake events and the exit counter
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      unique case (state_ff)
         ST_RUN, ST_LPRUN: begin
            if (sleep_req && !sleep_deep) begin
               // Low-power sleep only entered from low-power run
               nxt_state = (state_ff == ST_LPRUN) ?
                  ST_LPSLEEP : ST_SLEEP;
            end else if (sleep_req) begin
               unique case (cfg.deep_sel)
                  DEEP_STOP0: nxt_state = ST_STOP0;
                  DEEP_STOP1: nxt_state = ST_STOP1;
                  DEEP_STOP2: nxt_state = ST_STOP2;
                  DEEP_STANDBY: nxt_state = ST_STANDBY;
               endcase
            end else if (cfg.lp_run) begin
               nxt_state = ST_LPRUN;
            end else begin
               nxt_state = ST_RUN;
            end
         end
         ST_SLEEP: begin
            if (any_wake) nxt_state = ST_RUN;
         end
         ST_LPSLEEP: begin
            if (any_wake) nxt_state = ST_LPRUN;
         end
         ST_STOP0: begin
            if (any_wake) begin
               nxt_state = ST_STOP_EXIT;
               nxt_cnt = STOP0_CYC;
            end
         end
         ST_STOP1: begin
            if (any_wake) begin
               nxt_state = ST_STOP_EXIT;
               nxt_cnt = STOP1_CYC;
            end
         end
         ST_STOP2: begin
            // Only a subset of sources can wake Stop 2
            if (|(wake_s & STOP2_MASK)) begin
               nxt_state = ST_STOP_EXIT;
               nxt_cnt = STOP2_CYC;
            end
         end
         ST_STANDBY: begin
            if (|(wake_s & STBY_MASK)) begin
               nxt_state = ST_STBY_EXIT;
               nxt_cnt = STBY_CYC;
            end
         end
         ST_STOP_EXIT, ST_STBY_EXIT: begin
            if (cnt_ff <= `CNT_W'(1)) nxt_state = ST_RUN;
            else nxt_cnt = cnt_ff - `CNT_W'(1);
         end
         default: nxt_state = ST_RUN;
      endcase
   end

   // Mode register; brown-out reset forces Run
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) state_ff <= ST_RUN;
      else if (!chip_reset_n) state_ff <= ST_RUN;
      else state_ff <= nxt_state;
   end

   // Exit wait counter
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) cnt_ff <= '0;
      else if (!chip_reset_n) cnt_ff <= '0;
      else cnt_ff <= nxt_cnt;
   end

   // Reset pulse issued as Standby wake begins
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) standby_exit_reset <= 1'b0;
      else standby_exit_reset <= (state_ff == ST_STANDBY) &&
                                 (nxt_state == ST_STBY_EXIT);
   end

   // System clock source latched on leaving Stop
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) sysclk_src <= EXIT_MS_RC;
      else if (!chip_reset_n) sysclk_src <= EXIT_MS_RC;
      else if (state_ff inside {ST_STOP0, ST_STOP1, ST_STOP2} &&
               nxt_state == ST_STOP_EXIT)
         sysclk_src <= cfg.exit_clk;
   end

   ////////////////////////////////////////////////////////////////////
   // Clock, power and I/O controls

   clk_gate_type nxt_clk;
   power_ctrl_type nxt_pwr;
   logic in_lp;

   assign in_lp = (state_ff == ST_LPRUN) || (state_ff == ST_LPSLEEP);

   // Clock gating per mode
   always_comb begin
      nxt_clk = '{default: 1'b1};
      unique case (state_ff)
         ST_SLEEP: nxt_clk.cpu_clk_en = 1'b0;
         ST_LPRUN: begin
            nxt_clk.pll_en = 1'b0;
            nxt_clk.periph_fast_rc_ok = 1'b1;
         end
         ST_LPSLEEP: begin
            nxt_clk.cpu_clk_en = 1'b0;
            nxt_clk.pll_en = 1'b0;
         end
         ST_STOP0, ST_STOP1, ST_STOP2: begin
            nxt_clk.cpu_clk_en = 1'b0;
            nxt_clk.core_clk_en = 1'b0;
            nxt_clk.pll_en = 1'b0;
            nxt_clk.multispeed_rc_osc_en = 1'b0;
            nxt_clk.external_fast_crystal_en = 1'b0;
            nxt_clk.internal_fast_rc_osc_en = rc_req_s;
            nxt_clk.periph_fast_rc_ok = rc_req_s;
            nxt_clk.rtc_en = cfg.rtc_in_stop;
         end
         ST_STANDBY: begin
            nxt_clk.cpu_clk_en = 1'b0;
            nxt_clk.core_clk_en = 1'b0;
            nxt_clk.pll_en = 1'b0;
            nxt_clk.multispeed_rc_osc_en = 1'b0;
            nxt_clk.internal_fast_rc_osc_en = 1'b0;
            nxt_clk.external_fast_crystal_en = 1'b0;
            nxt_clk.periph_fast_rc_ok = 1'b0;
            nxt_clk.rtc_en = cfg.rtc_in_standby;
         end
         ST_STOP_EXIT, ST_STBY_EXIT: begin
            // Core waits for its supply and clock to settle
            nxt_clk.cpu_clk_en = 1'b0;
            nxt_clk.pll_en = 1'b0;
            nxt_clk.external_fast_crystal_en = 1'b0;
         end
         default: ;
      endcase
   end

   // Regulator and retention per mode
   always_comb begin
      nxt_pwr = '{default: 1'b1};
      nxt_pwr.lp_reg_on = 1'b0;
      nxt_pwr.low_leakage = 1'b0;
      unique case (state_ff)
         ST_LPRUN, ST_LPSLEEP, ST_STOP1: begin
            nxt_pwr.main_reg_on = 1'b0;
            nxt_pwr.lp_reg_on = 1'b1;
         end
         ST_STOP2: begin
            nxt_pwr.main_reg_on = 1'b0;
            nxt_pwr.lp_reg_on = 1'b1;
            nxt_pwr.low_leakage = 1'b1;
         end
         ST_STANDBY: begin
            nxt_pwr.main_reg_on = 1'b0;
            nxt_pwr.core_powered = 1'b0;
            nxt_pwr.primary_ram_keep = 1'b0;
            nxt_pwr.regs_keep = 1'b0;
            nxt_pwr.secondary_ram_keep = cfg.secondary_ram_keep;
         end
         default: ;
      endcase
   end

   // Registered control outputs; Stop 0 keeps main regulator on
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         clk_gate <= '{default: 1'b1};
         pwr_ctrl <= '{default: 1'b1, lp_reg_on: 1'b0,
                       low_leakage: 1'b0};
      end else begin
         clk_gate <= nxt_clk;
         pwr_ctrl <= nxt_pwr;
      end
   end

   // Core clock divider capped in low-power modes
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) cpu_div <= `CPU_DIV_RST;
      else if (in_lp) cpu_div <= cap_div(cfg.cpu_div);
      else cpu_div <= cfg.cpu_div;
   end

   // I/O pulls applied only while in Standby
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         io_pull_up <= '0;
         io_pull_down <= '0;
      end else if (state_ff == ST_STANDBY) begin
         io_pull_up <= cfg.io_pu;
         io_pull_down <= cfg.io_pd & ~cfg.io_pu;
      end else begin
         io_pull_up <= '0;
         io_pull_down <= '0;
      end
   end

endmodule

`default_nettype wire

// *** bench/lpmc_core_model.sv ***
/*
 Core model: wait instruction to one-cycle sleep request.
 Assumes wfi is raised for one cycle after setup.
*/
`timescale 1ns/1ps
`default_nettype none

module lpmc_core_model (
   input wire logic sys_clk, // System clock
   input wire logic wfi, // Wait instruction issued
   input wire logic deep, // Deep sleep chosen
   output logic sleep_req, // Request pulse to controller
   output logic sleep_deep // Deep choice with the request
);
   // Idle until the first instruction
   initial begin
      sleep_req = 1'b0;
      sleep_deep = 1'b0;
   end
   // Request launched just after the edge, one cycle long
   always @(posedge sys_clk) begin
      sleep_req <= #1 wfi;
      sleep_deep <= #1 deep;
   end
endmodule
`default_nettype wire

// *** bench/low_power_mode_controller_properties.sv ***
/*
 Port checker of the mode controller.
 Assumes bind into it; sees ports only.
*/
`timescale 1ns/1ps
`default_nettype none

module low_power_mode_controller_properties
   import lpmc_pkg::*;
(
   input wire logic sys_clk, // Clock
   input wire logic rstn, // Reset, low
   input wire logic brownout_below, // Low supply
   input wire logic det_en, // Detector enable
   input wire logic chip_reset_n, // Chip reset
   input wire logic bo_monitor_en, // Monitor on
   input wire logic supply_detector_en, // Detector on
   input wire logic supply_detector_irq, // Detector pulse
   input wire pm_state_type mode, // Mode
   input wire clk_gate_type clk_gate, // Clocks
   input wire power_ctrl_type pwr_ctrl, // Power
   input wire logic [`DIV_W-1:0] cpu_div // Divider
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   ////////////////////////////////////////////////////////////////////
   // Supply supervision
   property p_bo_hold;
      brownout_below [*4] |-> !chip_reset_n;
   endproperty
   a_bo_hold: assert property (p_bo_hold)
      else $error("no reset on low supply");
   property p_bo_on;
      bo_monitor_en;
   endproperty
   a_bo_on: assert property (p_bo_on)
      else $error("monitor off");
   property p_det_en;
      supply_detector_en == det_en;
   endproperty
   a_det_en: assert property (p_det_en)
      else $error("detector enable wrong");
   property p_irq_quiet;
      !det_en [*6] |-> !supply_detector_irq;
   endproperty
   a_irq_quiet: assert property (p_irq_quiet)
      else $error("irq while disabled");

   ////////////////////////////////////////////////////////////////////
   // Mode controls
   property p_sleep;
      $stable(mode) && mode == ST_SLEEP |->
         !clk_gate.cpu_clk_en && clk_gate.core_clk_en;
   endproperty
   a_sleep: assert property (p_sleep)
      else $error("sleep gating wrong");
   property p_lprun;
      $stable(mode) && mode == ST_LPRUN |->
         pwr_ctrl.lp_reg_on && cpu_div >= 4'h3;
   endproperty
   a_lprun: assert property (p_lprun)
      else $error("lp run wrong");
   property p_lps_from;
      $changed(mode) && mode == ST_LPSLEEP |-> $past(mode) == ST_LPRUN;
   endproperty
   a_lps_from: assert property (p_lps_from)
      else $error("lp sleep entry wrong");
   property p_lps_wake;
      chip_reset_n && $past(mode) == ST_LPSLEEP && mode != ST_LPSLEEP
         |-> mode == ST_LPRUN;
   endproperty
   a_lps_wake: assert property (p_lps_wake)
      else $error("lp sleep wake wrong");
   property p_stop;
      $stable(mode) && mode inside {ST_STOP0, ST_STOP1, ST_STOP2} |->
         !clk_gate.core_clk_en && !clk_gate.pll_en &&
         !clk_gate.multispeed_rc_osc_en &&
         !clk_gate.external_fast_crystal_en && clk_gate.slow_osc_en &&
         pwr_ctrl.primary_ram_keep;
   endproperty
   a_stop: assert property (p_stop)
      else $error("stop gating wrong");
   property p_stby;
      $stable(mode) && mode == ST_STANDBY |-> !pwr_ctrl.main_reg_on &&
         !pwr_ctrl.core_powered && !pwr_ctrl.primary_ram_keep &&
         pwr_ctrl.backup_keep && !clk_gate.pll_en;
   endproperty
   a_stby: assert property (p_stby)
      else $error("standby power wrong");
endmodule

bind low_power_mode_controller low_power_mode_controller_properties
   u_props (.sys_clk, .rstn, .brownout_below, .det_en, .chip_reset_n,
   .bo_monitor_en, .supply_detector_en, .supply_detector_irq, .mode,
   .clk_gate, .pwr_ctrl, .cpu_div);
`default_nettype wire

// *** bench/low_power_mode_controller_test.sv ***
/*
 Bench of the mode controller: supply and mode paths.
 Assumes package, core model and checker compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module low_power_mode_controller_test
   import lpmc_pkg::*;
;
   logic sys_clk, rstn, brownout_below, supply_above, option_valid;
   logic det_en, det_rise_en, det_fall_en, periph_fast_rc_req, wfi, deep;
   logic [2:0] option_bo_level, bo_level;
   logic [7:0] wake_evt;
   lp_cfg_type cfg;
   logic sleep_req, sleep_deep, chip_reset_n, bo_monitor_en;
   logic supply_detector_en, supply_detector_irq, standby_exit_reset;
   pm_state_type mode;
   clk_gate_type clk_gate;
   power_ctrl_type pwr_ctrl;
   exit_clk_type sysclk_src;
   logic [3:0] cpu_div;
   logic [15:0] io_pull_up, io_pull_down;
   int fail_count = 0;
   int n_compared = 0;
   int cyc = 0;

   lpmc_core_model core (.sys_clk, .wfi, .deep, .sleep_req, .sleep_deep);
   low_power_mode_controller DUT (.sys_clk, .rstn, .brownout_below,
      .supply_above, .option_bo_level, .option_valid, .det_en,
      .det_rise_en, .det_fall_en, .cfg, .sleep_req, .sleep_deep,
      .wake_evt, .periph_fast_rc_req, .chip_reset_n, .bo_level,
      .bo_monitor_en, .supply_detector_en, .supply_detector_irq,
      .supply_level(), .mode, .clk_gate, .pwr_ctrl, .sysclk_src,
      .cpu_div, .io_pull_up, .io_pull_down, .standby_exit_reset);

   ////////////////////////////////////////////////////////////////////
   // Clock and hang guard
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 10000) begin
         fail_count++;
         test_done();
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic tick(input int n = 1);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_compared++;
      if (e !== g) begin
         fail_count++;
         $display("[ERR] %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic wait_mode(input pm_state_type m);
      int i = 0;
      while (mode !== m && i < 3000) begin
         tick();
         i++;
      end
      chk("mode", m, mode);
   endtask
   task automatic req(input logic d);
      wfi = 1'b1;
      deep = d;
      tick();
      wfi = 1'b0;
   endtask
   task automatic wake(input logic [7:0] b);
      wake_evt = b;
      tick(4);
      wake_evt = 8'h00;
      tick(2);
   endtask
   task automatic irq_count(output int n);
      n = 0;
      repeat (8) begin
         tick();
         if (supply_detector_irq === 1'b1) n++;
      end
   endtask
   task automatic done(input string s);
      $display("test %s done, mismatches %0d", s, fail_count);
   endtask
   task automatic test_done();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_supply();
      int n;
      chk("mode", ST_RUN, mode);
      chk("bo_level", 3'h0, bo_level);
      option_bo_level = 3'h5;
      option_valid = 1'b1;
      tick();
      option_valid = 1'b0;
      tick(2);
      chk("bo_level", 3'h5, bo_level);
      brownout_below = 1'b1;
      tick(5);
      chk("chip_reset_n", 1'b0, chip_reset_n);
      brownout_below = 1'b0;
      tick(5);
      chk("chip_reset_n", 1'b1, chip_reset_n);
      det_en = 1'b1;
      det_rise_en = 1'b1;
      tick(6);
      supply_above = 1'b1;
      irq_count(n);
      chk("irq rise", 1, n);
      supply_above = 1'b0;
      irq_count(n);
      chk("irq fall off", 0, n);
      det_en = 1'b0;
      det_fall_en = 1'b1;
      supply_above = 1'b1;
      irq_count(n);
      chk("irq disabled", 0, n);
      done("supply");
   endtask

   task automatic t_sleep();
      req(1'b0);
      wait_mode(ST_SLEEP);
      wake(8'h80);
      wait_mode(ST_RUN);
      cfg.lp_run = 1'b1;
      wait_mode(ST_LPRUN);
      tick(2);
      chk("fast rc ok", 1'b1, clk_gate.periph_fast_rc_ok);
      req(1'b0);
      wait_mode(ST_LPSLEEP);
      wake(8'h40);
      wait_mode(ST_LPRUN);
      cfg.lp_run = 1'b0;
      wait_mode(ST_RUN);
      done("sleep");
   endtask

   task automatic t_stop(input logic [1:0] s);
      cfg.deep_sel = deep_sel_type'(s);
      cfg.exit_clk = exit_clk_type'(s[0]);
      cfg.rtc_in_stop = s[0];
      req(1'b1);
      wait_mode(s == 2'h0 ? ST_STOP0 : s == 2'h1 ? ST_STOP1 : ST_STOP2);
      periph_fast_rc_req = 1'b1;
      tick(4);
      chk("rtc", s[0], clk_gate.rtc_en);
      chk("fast rc", 1'b1, clk_gate.internal_fast_rc_osc_en);
      chk("main reg", s == 2'h0, pwr_ctrl.main_reg_on);
      chk("leakage", s == 2'h2, pwr_ctrl.low_leakage);
      periph_fast_rc_req = 1'b0;
      wake(8'h10);
      if (s == 2'h2) begin
         chk("mode", ST_STOP2, mode);
         wake(8'h01);
      end
      wait_mode(ST_STOP_EXIT);
      chk("exit clk", s[0], sysclk_src);
      wait_mode(ST_RUN);
      done("stop");
   endtask

   task automatic t_standby();
      int n = 0, i = 0;
      cfg.deep_sel = DEEP_STANDBY;
      cfg.io_pu = 16'h00F0;
      cfg.io_pd = 16'h0F00;
      cfg.rtc_in_standby = 1'b1;
      cfg.secondary_ram_keep = 1'b1;
      req(1'b1);
      wait_mode(ST_STANDBY);
      tick(2);
      chk("pull up", 16'h00F0, io_pull_up);
      chk("pull down", 16'h0F00, io_pull_down);
      chk("rtc", 1'b1, clk_gate.rtc_en);
      chk("ram2", 1'b1, pwr_ctrl.secondary_ram_keep);
      chk("bo mon", 1'b1, bo_monitor_en);
      wake(8'h08);
      chk("mode", ST_STANDBY, mode);
      wake_evt = 8'h02;
      while (mode !== ST_RUN && i < 3000) begin
         tick();
         i++;
         if (standby_exit_reset === 1'b1) n++;
      end
      wake_evt = 8'h00;
      chk("exit reset", 1, n);
      chk("mode", ST_RUN, mode);
      done("standby");
   endtask

   ////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rstn = 1'b0;
      {brownout_below, supply_above, option_valid, det_en} = 4'h0;
      {det_rise_en, det_fall_en, periph_fast_rc_req, wfi, deep} = 5'h00;
      option_bo_level = 3'h0;
      wake_evt = 8'h00;
      cfg = '0;
      tick(4);
      rstn = 1'b1;
      tick(5);
      t_supply();
      t_sleep();
      for (int s = 0; s < 3; s++) t_stop(2'(s));
      t_standby();
      test_done();
   end
endmodule
`default_nettype wire
